// ### verilog/pct_defines.svh
// Offsets, field positions, reset values and counts of the prescaled timer
`ifndef PCT_DEFINES_SVH
`define PCT_DEFINES_SVH

// Global register numbers reached with the high flag set
`define PCT_GREG_PRESCALE   5'h15
`define PCT_GREG_COMPARE    5'h16
`define PCT_GREG_COUNT      5'h17

// Prescale and clock control field positions
`define PCT_DEFER_BIT       31
`define PCT_RATIO_HI        27
`define PCT_RATIO_LO        26
`define PCT_FACTOR_HI       23
`define PCT_FACTOR_LO       16

// Function control mask bit position
`define PCT_FCR_MASK_BIT    23

// Reset values
`define PCT_RATIO_RST       2'h2
`define PCT_FACTOR_RST      8'h00
`define PCT_COUNT_RST       32'h0000_0000
`define PCT_COMPARE_RST     32'h0000_0000

// Prescaler terminal offset: divide by n+2 means count 0..n+1
`define PCT_DIV_OFFSET      9'h001

`endif

// ### verilog/pct_pkg.sv
// Types shared by the prescaled timer modules
package pct_pkg;

    // Core clock relative to the crystal input clock
    typedef enum logic [1:0] {
        PCT_RATIO_X4   = 2'h0,
        PCT_RATIO_X2   = 2'h1,
        PCT_RATIO_X1   = 2'h2,
        PCT_RATIO_HALF = 2'h3
    } pct_ratio_t;

    // Which timer register a move instruction addresses
    typedef enum logic [1:0] {
        PCT_SEL_NONE,
        PCT_SEL_PRESCALE,
        PCT_SEL_COMPARE,
        PCT_SEL_COUNT
    } pct_sel_t;

endpackage : pct_pkg

// ### verilog/pct_div_if.sv
// Link between the timer core and its prescale divider
interface pct_div_if;
    logic       reload;
    logic [7:0] factor;
    logic       carry;

    modport core (output reload, output factor, input carry);
    modport div  (input reload, input factor, output carry);
endinterface : pct_div_if

// ### verilog/pct_prescaler.sv
// Prescale divider producing one carry per basic time unit
`include "pct_defines.svh"

module pct_prescaler
    import pct_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Link to the timer core
    pct_div_if.div   dv
);

    logic [8:0] cnt_q;
    logic [8:0] term;

    assign term     = {1'b0, dv.factor} + `PCT_DIV_OFFSET;
    assign dv.carry = (cnt_q == term) && !dv.reload; // see RULE_02 RULE_03

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_q <= 9'h000;
        end else if (dv.reload || dv.carry) begin
            cnt_q <= 9'h000; // see RULE_17
        end else begin
            cnt_q <= cnt_q + 9'h001;
        end
    end

endmodule : pct_prescaler

// ### verilog/pct_timer.sv
// Prescaled timer with 32-bit count, compare and clock ratio control
//
// What this block and its software do
// RULE_01 - Prescale register is write only
// RULE_02 - Prescaler carry increments count modulo 2^32
// RULE_03 - Time unit is clock divided by n+2
// RULE_04 - Bit 31 clear: apply ratio, reload immediately
// RULE_05 - Bit 31 set: apply both at unit end
// RULE_06 - Bits 27..26 select core clock ratio
// RULE_07 - Pin or clock-down reset: ratio 10, n=0
// RULE_08 - Watchdog reset keeps prescale register
// RULE_09 - Software writes reserved bits as zero
// RULE_10 - Past compare when difference bit 31 zero
// RULE_11 - Unmasked and past compare asserts interrupt
// RULE_12 - Mask bit 23 set on reset, counting continues
// RULE_13 - Registers reached by moves with high flag
// RULE_14 - Software loads prescaler then count once
// RULE_15 - Software compare is count plus delay
// RULE_16 - Timer keeps running during power-down
// RULE_17 - Immediate write restarts prescale count at zero
`include "pct_defines.svh"

module pct_timer
    import pct_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // Reset sources from the reset controller, same clock
    input  wire logic        clkdown_rst,
    input  wire logic        wdog_rst,
    // Move instruction access to global registers
    input  wire logic        high_flag,
    input  wire logic [4:0]  greg_num,
    input  wire logic        mov_wr,
    input  wire logic        mov_rd,
    input  wire logic [31:0] wr_data,
    output logic      [31:0] rd_data_q,
    // Function control register mask write
    input  wire logic        fcr_wr,
    input  wire logic [31:0] fcr_data,
    // Status and control outputs
    output logic             timer_irq_q,
    output pct_ratio_t       core_clock_ratio_q,
    output logic      [31:0] time_count_q,
    output logic             timer_mask_q
);

    ////////////////////////////////////////////////////////////////////////

    pct_div_if div_link ();

    logic [7:0]  prescale_factor_q;
    logic [7:0]  pend_factor_q;
    pct_ratio_t  pend_ratio_q;
    logic        pend_valid_q;
    logic [31:0] time_compare_q;
    logic [31:0] diff;
    pct_sel_t    sel;
    logic        tpr_wr;
    logic        defer;
    logic        init_rst;
    logic        apply_now;
    logic        apply_late;
    logic        cnt_wr;
    logic        cmp_wr;
    logic        past_cmp;

    ////////////////////////////////////////////////////////////////////////
    // Decoding helpers

    // Only moves with the high flag reach the timer registers
    function automatic pct_sel_t decode(input logic hf, input logic [4:0] g);
        pct_sel_t s;
        s = PCT_SEL_NONE;
        if (hf) begin
            case (g)
                `PCT_GREG_PRESCALE: s = PCT_SEL_PRESCALE;
                `PCT_GREG_COMPARE:  s = PCT_SEL_COMPARE;
                `PCT_GREG_COUNT:    s = PCT_SEL_COUNT;
                default:            s = PCT_SEL_NONE;
            endcase
        end
        return s;
    endfunction : decode

    // Field extraction shared by the immediate and deferred paths
    function automatic logic [7:0] factor_field(input logic [31:0] w);
        return w[`PCT_FACTOR_HI:`PCT_FACTOR_LO];
    endfunction : factor_field

    function automatic pct_ratio_t ratio_field(input logic [31:0] w);
        return pct_ratio_t'(w[`PCT_RATIO_HI:`PCT_RATIO_LO]);
    endfunction : ratio_field

    // Modulo compare by the sign of the difference: a plain magnitude test would misjudge a wrapped count
    function automatic logic at_or_past(input logic [31:0] d);
        return !d[31];
    endfunction : at_or_past

    ////////////////////////////////////////////////////////////////////////
    // Write strobes

    assign sel      = decode(high_flag, greg_num); // see RULE_13
    assign tpr_wr   = mov_wr && (sel == PCT_SEL_PRESCALE);
    assign cnt_wr   = mov_wr && (sel == PCT_SEL_COUNT);
    assign cmp_wr   = mov_wr && (sel == PCT_SEL_COMPARE);
    assign defer    = wr_data[`PCT_DEFER_BIT];
    // Watchdog reset deliberately absent: the time base must survive it
    assign init_rst = clkdown_rst; // see RULE_08
    // A clock-down reset outranks any prescale write in the same cycle
    assign apply_now  = !init_rst && tpr_wr && !defer; // see RULE_04
    // Deferred values wait for the carry that ends the running unit
    assign apply_late = !init_rst && !tpr_wr && pend_valid_q
                        && div_link.carry; // see RULE_05

    assign div_link.factor = prescale_factor_q;
    assign div_link.reload = init_rst || apply_now; // see RULE_04 RULE_17

    pct_prescaler u_prescaler (
        .clk     (clk),
        .sys_rst (sys_rst),
        .dv      (div_link)
    );

    ////////////////////////////////////////////////////////////////////////
    // Prescale and clock control

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            prescale_factor_q  <= `PCT_FACTOR_RST; // see RULE_07
            core_clock_ratio_q <= pct_ratio_t'(`PCT_RATIO_RST);
            pend_factor_q      <= `PCT_FACTOR_RST;
            pend_ratio_q       <= pct_ratio_t'(`PCT_RATIO_RST);
            pend_valid_q       <= 1'b0;
        end else if (init_rst) begin
            prescale_factor_q  <= `PCT_FACTOR_RST; // see RULE_07
            core_clock_ratio_q <= pct_ratio_t'(`PCT_RATIO_RST);
            pend_valid_q       <= 1'b0;
        end else if (apply_now) begin
            prescale_factor_q  <= factor_field(wr_data); // see RULE_03
            core_clock_ratio_q <= ratio_field(wr_data); // see RULE_06
            pend_valid_q       <= 1'b0;
        end else if (tpr_wr) begin
            pend_factor_q <= factor_field(wr_data);
            pend_ratio_q  <= ratio_field(wr_data);
            pend_valid_q  <= 1'b1; // see RULE_05
        end else if (apply_late) begin
            // Both change together so absolute time is kept
            prescale_factor_q  <= pend_factor_q; // see RULE_05
            core_clock_ratio_q <= pend_ratio_q;
            pend_valid_q       <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Time count: runs regardless of power-down, which only halts the pipe

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            time_count_q <= `PCT_COUNT_RST;
        end else if (cnt_wr) begin
            // A count write beats a carry landing in the same cycle
            time_count_q <= wr_data;
        end else if (div_link.carry) begin
            time_count_q <= time_count_q + 32'h1; // see RULE_02 RULE_16
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            time_compare_q <= `PCT_COMPARE_RST;
        end else if (cmp_wr) begin
            // The compare value, with the count and the mask, decides when the interrupt clears
            time_compare_q <= wr_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Compare and interrupt

    // Difference stays live; the mask never stops the compare
    assign diff     = time_count_q - time_compare_q; // see RULE_10
    assign past_cmp = at_or_past(diff); // see RULE_10

    // Clock-down keeps the mask so a wakeup sees the right masking
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            timer_mask_q <= 1'b1; // see RULE_12
        end else if (wdog_rst) begin
            timer_mask_q <= 1'b1; // see RULE_12
        end else if (fcr_wr) begin
            timer_mask_q <= fcr_data[`PCT_FCR_MASK_BIT];
        end
    end

    // Level tracks count, compare and mask: a later compare, an earlier count or a set mask clears it
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            timer_irq_q <= 1'b0;
        end else begin
            timer_irq_q <= !timer_mask_q && past_cmp; // see RULE_11
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_data_q <= 32'h0000_0000;
        end else if (mov_rd) begin
            case (sel)
                PCT_SEL_COUNT:    rd_data_q <= time_count_q;
                PCT_SEL_COMPARE:  rd_data_q <= time_compare_q;
                // Write only: a read gives zero; only the ratio field leaves, on core_clock_ratio_q
                PCT_SEL_PRESCALE: rd_data_q <= 32'h0000_0000; // see RULE_01
                default:          rd_data_q <= 32'h0000_0000;
            endcase
        end
    end

endmodule : pct_timer

// ### dv/pct_timer_checker.sv
// Port-level assertions for the prescaled timer
module pct_timer_checker
    import pct_pkg::*;
(
    // Clock and resets
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        clkdown_rst,
    input wire logic        wdog_rst,
    // Moves and function control
    input wire logic        high_flag,
    input wire logic [4:0]  greg_num,
    input wire logic        mov_wr,
    input wire logic        mov_rd,
    input wire logic [31:0] wr_data,
    input wire logic        fcr_wr,
    input wire logic [31:0] fcr_data,
    // Outputs of the block
    input wire logic [31:0] rd_data_q,
    input wire logic        timer_irq_q,
    input wire pct_ratio_t  core_clock_ratio_q,
    input wire logic [31:0] time_count_q,
    input wire logic        timer_mask_q
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Moves the block takes, decoded once
    wire pw = mov_wr && high_flag && greg_num == 5'h15;
    wire cw = mov_wr && high_flag && greg_num == 5'h17;
    ////////////////////////////////////////////////////////////////////////
    a_count_step: assert property (
        $changed(time_count_q) && !$past(cw) |->
        time_count_q == $past(time_count_q) + 32'h1) else $error("step");
    a_count_write: assert property (
        cw |=> time_count_q == $past(wr_data)) else $error("count wr");
    a_mask_quiet: assert property (
        timer_mask_q [*2] |-> !timer_irq_q) else $error("masked irq");
    a_wdog_mask: assert property (
        wdog_rst |=> timer_mask_q) else $error("wdog mask");
    a_clkdown_ratio: assert property (
        clkdown_rst |=> core_clock_ratio_q == PCT_RATIO_X1) else $error("cd");
    a_ratio_now: assert property (
        pw && !wr_data[31] && !clkdown_rst |=>
        core_clock_ratio_q == $past(wr_data[27:26])) else $error("ratio");
    a_prescale_read: assert property (
        mov_rd && high_flag && greg_num == 5'h15 |=> rd_data_q == 32'h0)
        else $error("read prescale");
    a_fcr_mask: assert property (
        fcr_wr && !wdog_rst |=> timer_mask_q == $past(fcr_data[23]))
        else $error("fcr mask");
    cover property (cw);
    cover property (timer_irq_q);
    cover property (pw && wr_data[31]);
endmodule : pct_timer_checker

bind pct_timer pct_timer_checker u_chk (.clk, .sys_rst, .clkdown_rst,
    .wdog_rst, .high_flag, .mov_wr, .mov_rd, .fcr_wr, .timer_irq_q,
    .timer_mask_q, .greg_num, .wr_data, .fcr_data, .rd_data_q,
    .time_count_q, .core_clock_ratio_q);

// ### dv/tb_pct_timer.sv
// Self-checking bench for the prescaled timer
module tb_pct_timer import pct_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, sys_rst, clkdown_rst, wdog_rst, high_flag;
    logic mov_wr, mov_rd, fcr_wr, timer_irq_q, timer_mask_q;
    logic [4:0]  greg_num;
    logic [31:0] wr_data, fcr_data, rd_data_q, time_count_q, c;
    pct_ratio_t  core_clock_ratio_q;
    int          err_total, comparisons, cyc, g;

    pct_timer dut (.clk, .sys_rst, .clkdown_rst, .wdog_rst, .high_flag,
        .greg_num, .mov_wr, .mov_rd, .wr_data, .rd_data_q, .fcr_wr,
        .fcr_data, .timer_irq_q, .core_clock_ratio_q, .time_count_q,
        .timer_mask_q);
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Hang guard well above the hundred or so cycles the run needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        if (err_total == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : tally_and_finish
    task automatic chk(string n, logic [31:0] e, logic [31:0] s);
        comparisons++;
        if (s !== e) begin
            err_total++;
            $display("mismatch %s exp %h got %h", n, e, s);
        end
    endtask : chk
    task automatic tick(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    // Leading tick keeps a lowered strobe from rising in the same step
    task automatic mv(logic h, logic [4:0] n, logic [31:0] d);
        tick(1);
        {high_flag, greg_num, wr_data, mov_wr} = {h, n, d, 1'b1};
        tick(1);
        mov_wr = 1'b0;
    endtask : mv
    task automatic pulse(ref logic s);
        tick(1);
        s = 1'b1;
        tick(1);
        s = 1'b0;
    endtask : pulse
    task automatic rd(logic [4:0] n);
        greg_num = n;
        pulse(mov_rd);
    endtask : rd
    task automatic gap();
        c = time_count_q;
        for (g = 0; time_count_q === c && g < 600; g++) tick(1);
    endtask : gap
    function automatic logic [31:0] pv(logic d, logic [1:0] r, logic [7:0] n);
        return {d, 3'h0, r, 2'h0, n, 16'h0000};
    endfunction : pv
    ////////////////////////////////////////////////////////////////////////
    task automatic t_ratio();
        for (int i = 0; i < 4; i++) begin
            mv(1'b1, 5'h15, pv(1'b0, 2'(i), 8'h03));
            chk("ratio", i, core_clock_ratio_q);
        end
        gap();
        chk("first unit", 5, g);
        gap();
        chk("unit", 5, g);
    endtask : t_ratio
    task automatic t_defer();
        mv(1'b1, 5'h15, pv(1'b0, 2'h0, 8'h03));
        mv(1'b1, 5'h15, pv(1'b1, 2'h3, 8'h00));
        chk("held ratio", PCT_RATIO_X4, core_clock_ratio_q);
        gap();
        chk("late ratio", PCT_RATIO_HALF, core_clock_ratio_q);
        gap();
        chk("late unit", 2, g);
    endtask : t_defer
    task automatic t_count();
        mv(1'b1, 5'h15, pv(1'b0, 2'h1, 8'hFF));
        mv(1'b1, 5'h17, 32'hFFFF_FFFF);
        mv(1'b0, 5'h17, 32'h0000_005A);
        chk("count", 32'hFFFF_FFFF, time_count_q);
        mv(1'b1, 5'h16, 32'h1234_5678);
        rd(5'h16);
        chk("compare read", 32'h1234_5678, rd_data_q);
        rd(5'h17);
        chk("count read", 32'hFFFF_FFFF, rd_data_q);
        rd(5'h15);
        chk("prescale read", 0, rd_data_q);
        mv(1'b1, 5'h15, pv(1'b0, 2'h1, 8'h00));
        gap();
        chk("wrap", 0, time_count_q);
    endtask : t_count
    task automatic t_irq();
        pulse(fcr_wr);
        chk("mask", 0, timer_mask_q);
        mv(1'b1, 5'h16, time_count_q + 32'h30);
        tick(1);
        chk("irq", 0, timer_irq_q);
        mv(1'b1, 5'h16, time_count_q);
        tick(1);
        chk("irq", 1, timer_irq_q);
        mv(1'b1, 5'h16, time_count_q + 32'h7FFF_FFFF);
        tick(1);
        chk("irq", 0, timer_irq_q);
        mv(1'b1, 5'h16, time_count_q + 32'h8000_0004);
        tick(1);
        chk("irq", 1, timer_irq_q);
        mv(1'b1, 5'h15, pv(1'b0, 2'h1, 8'h03));
        pulse(wdog_rst);
        tick(1);
        chk("wdog irq", 0, timer_irq_q);
        chk("wdog ratio", PCT_RATIO_X2, core_clock_ratio_q);
        gap();
        gap();
        chk("wdog unit", 5, g);
        mv(1'b1, 5'h15, pv(1'b0, 2'h0, 8'h03));
        pulse(fcr_wr);
        pulse(clkdown_rst);
        chk("cd ratio", PCT_RATIO_X1, core_clock_ratio_q);
        chk("cd mask", 0, timer_mask_q);
        gap();
        gap();
        chk("cd unit", 2, g);
    endtask : t_irq
    initial begin
        {sys_rst, clkdown_rst, wdog_rst, high_flag, mov_wr} = 5'h10;
        {mov_rd, fcr_wr, greg_num, wr_data, fcr_data} = '0;
        tick(4);
        sys_rst = 1'b0;
        chk("rst mask", 1, timer_mask_q);
        chk("rst ratio", PCT_RATIO_X1, core_clock_ratio_q);
        t_ratio();
        t_defer();
        t_count();
        t_irq();
        tally_and_finish();
    end
endmodule : tb_pct_timer
